/* File: scp_pkg.sv */
// constants, field layouts and mode codes of the serial command port
// assumes: one ref_clk system domain plus the host-driven serial clock
//
// Contract
// - one 16-bit word in, one out per frame
// - frame only while chip select low
// - valid word adopted at chip select rise
// - output released when chip select high
// - input sampled on serial clock falling edge
// - output advances after serial clock rising edge
// - length not sixteen discards the word
// - length error flagged in next output word
// - no daisy chain, input never echoed
// - mode field zero invalidates whole word
// - forbidden mode transition ignored
// - corrupted command sets failure, raises interrupt
// - corrupted command repeats previous output word, length flag refreshed
// - wake state bit mirrors wake pin
// - decode flash, normal, sleep, stop requests
// - restart only from software flash
// - fail-safe only in software development mode
// - mode 111 reads target, writes nothing
// - output mode field reports current mode
// - target field selects eight configuration targets
// - restart and init entered autonomously
// - interrupt sources enabled after reset
package scp_pkg;

  // ==========================================================
  // word geometry
  localparam int WORD_BITS = 16;
  localparam int CNT_W = 6;
  localparam logic [5:0] FRAME_LEN = 6'h10;
  localparam logic [5:0] CNT_MAX = 6'h3f;
  localparam logic [4:0] RO_LATCH_IDX = 5'h07;
  localparam logic [4:0] DATA_IDX = 5'h08;
  localparam logic [4:0] LAST_IDX = 5'h0f;

  // ==========================================================
  // operating modes, shared by input request and output report
  typedef enum logic [2:0] {
    SCP_INIT = 3'b000,
    SCP_RESTART = 3'b001,
    SCP_FLASH = 3'b010,
    SCP_NORMAL = 3'b011,
    SCP_SLEEP = 3'b100,
    SCP_STOP = 3'b101,
    SCP_FAILSAFE = 3'b110,
    SCP_READONLY = 3'b111
  } scp_mode_e;

  // ==========================================================
  // configuration targets
  localparam logic [2:0] TGT_WAKE_IRQ = 3'h0;
  localparam logic [2:0] TGT_DEV_IRQ = 3'h1;
  localparam logic [2:0] TGT_COMM_IRQ = 3'h2;
  localparam logic [2:0] TGT_RESERVED = 3'h3;
  localparam logic [2:0] TGT_DEV_CFG = 3'h4;
  localparam logic [2:0] TGT_COMM_SETUP = 3'h5;
  localparam logic [2:0] TGT_WD_CFG = 3'h6;
  localparam logic [2:0] TGT_LIMP_DIAG = 3'h7;
  localparam logic [7:0] IRQ_CFG_RST = 8'hff;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam int FAIL_EN_BIT = 4;

  // ==========================================================
  // frame layouts, bit 15 first on the wire
  typedef struct packed {
    logic watchdog_trigger_bit;
    logic [2:0] mode_select_field;
    logic [2:0] config_target_field;
    logic spare;
    logic [7:0] data;
  } scp_in_s;

  typedef struct packed {
    logic frame_error_flag;
    logic [2:0] mode_report;
    logic [2:0] config_target_field;
    logic wake_state;
    logic [7:0] data;
  } scp_out_s;

  localparam logic [15:0] TX_RST = 16'h0000;

endpackage : scp_pkg

/* File: scp_command_port.sv */
// serial command port: 16-bit target port with mode supervision
// assumes: host drives spi_clk idle low; chip_select_n stays high for
// at least four ref_clk periods between frames
`timescale 1ns/1ps
`default_nettype none

module scp_command_port
  import scp_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  // system clock and control
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // serial link pins
  input wire logic spi_clk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  // device pins and state
  input wire logic wake_input_pin,
  input wire logic sw_dev_mode,
  input wire logic force_restart,
  // results
  output scp_mode_e op_mode,
  output logic [7:0] cfg_regs [8],
  output logic cmd_fail,
  output logic cmd_fail_irq,
  output logic wd_trigger_pulse,
  output logic wd_trigger_level
);

  // ==========================================================
  // elaboration checks
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least 2");
  end

  // ==========================================================
  // link domain: receive side on falling serial clock edges
  // counters are cleared while the chip select is high, so each frame
  // starts counting from zero
  logic [15:0] rx_shift_q;
  logic [CNT_W-1:0] rx_cnt_q;

  always_ff @(negedge spi_clk or posedge chip_select_n) begin
    if (chip_select_n) begin
      rx_shift_q <= 16'h0000;
      rx_cnt_q <= '0;
    end else begin
      rx_shift_q <= {rx_shift_q[14:0], serial_in};
      if (rx_cnt_q != CNT_MAX) begin // saturate, long frames stay bad
        rx_cnt_q <= rx_cnt_q + 6'h01;
      end
    end
  end

  // ==========================================================
  // link domain: transmit index on rising serial clock edges
  logic [4:0] tx_idx_q;
  logic ro_frame_q;
  logic [2:0] ro_tgt_q;

  always_ff @(posedge spi_clk or posedge chip_select_n) begin
    if (chip_select_n) begin
      tx_idx_q <= 5'h00;
      ro_frame_q <= 1'b0;
      ro_tgt_q <= 3'h0;
    end else begin
      if (tx_idx_q != 5'h1f) begin
        tx_idx_q <= tx_idx_q + 5'h01;
      end
      // seven bits are in: mode and target fields are complete
      if (tx_idx_q == RO_LATCH_IDX) begin
        ro_frame_q <= (rx_shift_q[5:3] == SCP_READONLY);
        ro_tgt_q <= rx_shift_q[2:0];
      end
    end
  end

  // ==========================================================
  // frame capture on the rising chip select edge
  // the clears above act on the same edge; non-blocking assignment
  // keeps the pre-clear values here
  logic [15:0] frame_word_q;
  logic frame_len_ok_q;

  always_ff @(posedge chip_select_n) begin
    frame_word_q <= rx_shift_q;
    frame_len_ok_q <= (rx_cnt_q == FRAME_LEN);
  end

  // ==========================================================
  // serial output selection
  // tx_q belongs to the system domain and only changes between frames
  logic [15:0] tx_q;
  logic [7:0] rd_val [8];
  wire [3:0] bit_sel = 4'hf - tx_idx_q[3:0];
  wire in_word = (tx_idx_q <= LAST_IDX);
  wire in_data = (tx_idx_q >= DATA_IDX);
  wire [7:0] ro_data = rd_val[ro_tgt_q];
  wire ro_bit = ro_data[bit_sel[2:0]];
  // never forwards serial_in: no daisy chain path
  wire tx_bit = (ro_frame_q && in_data) ? ro_bit : tx_q[bit_sel];

  // released line reads low, never a stale transmit bit
  assign serial_out = (!chip_select_n && in_word) ? tx_bit : 1'b0;
  assign serial_out_oe = ~chip_select_n;

  // ==========================================================
  // system domain: synchronisers
  logic [SYNC_STAGES-1:0] cs_sync_q;
  logic [SYNC_STAGES-1:0] wake_sync_q;
  logic cs_prev_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cs_sync_q <= '1;
      wake_sync_q <= '0;
    end else if (clk_en) begin
      cs_sync_q <= {cs_sync_q[SYNC_STAGES-2:0], chip_select_n};
      wake_sync_q <= {wake_sync_q[SYNC_STAGES-2:0], wake_input_pin};
    end
  end

  wire cs_high = cs_sync_q[SYNC_STAGES-1];
  wire wake_level = wake_sync_q[SYNC_STAGES-1];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cs_prev_q <= 1'b1;
    end else if (clk_en) begin
      cs_prev_q <= cs_high;
    end
  end

  // frame words are stable by the time the synchronised rise appears
  wire frame_end = cs_high && !cs_prev_q;

  // ==========================================================
  // command decode
  scp_mode_e mode_q;
  logic [7:0] cfg_q [8];
  logic cmd_fail_q;
  scp_in_s cmd;

  assign cmd = scp_in_s'(frame_word_q);

  function automatic logic trans_allowed(scp_mode_e cur, logic [2:0] req,
                                         logic dev_mode);
    logic ok;
    ok = 1'b1;
    unique case (req)
      3'b001: ok = (cur == SCP_FLASH);
      3'b010: ok = (cur != SCP_STOP);
      3'b110: ok = dev_mode;
      3'b000: ok = 1'b0;
      3'b011, 3'b100, 3'b101, 3'b111: ok = 1'b1;
    endcase
    return ok;
  endfunction

  wire mode_zero = (cmd.mode_select_field == 3'b000);
  wire read_only = (cmd.mode_select_field == SCP_READONLY);
  wire trans_ok = trans_allowed(mode_q, cmd.mode_select_field, sw_dev_mode);
  wire corrupt = !frame_len_ok_q || mode_zero || !trans_ok;
  wire accept = frame_end && !corrupt;
  wire reject = frame_end && corrupt;
  wire do_write = accept && !read_only && (cmd.config_target_field != TGT_RESERVED);
  wire do_mode = accept && !read_only;
  wire rd_fail_tgt = accept && (cmd.config_target_field == TGT_DEV_IRQ);

  // ==========================================================
  // readback of the eight targets
  // interrupt targets report events; only the command failure is kept here
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      rd_val[i] = cfg_q[i];
    end
    rd_val[TGT_WAKE_IRQ] = 8'h00;
    rd_val[TGT_DEV_IRQ] = 8'h00;
    rd_val[TGT_DEV_IRQ][FAIL_EN_BIT] = cmd_fail_q;
    rd_val[TGT_COMM_IRQ] = 8'h00;
    rd_val[TGT_RESERVED] = 8'h00;
  end

  // ==========================================================
  // operating mode
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_q <= SCP_INIT;
    end else if (clk_en) begin
      if (force_restart) begin
        mode_q <= SCP_RESTART;
      end else if (do_mode) begin
        mode_q <= scp_mode_e'(cmd.mode_select_field);
      end
    end
  end

  // ==========================================================
  // configuration targets
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        cfg_q[i] <= (i < 3) ? IRQ_CFG_RST : CFG_RST;
      end
    end else if (clk_en && do_write) begin
      cfg_q[cmd.config_target_field] <= cmd.data;
    end
  end

  // ==========================================================
  // command failure status; a new failure wins over the read that clears
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmd_fail_q <= 1'b0;
    end else if (clk_en) begin
      if (reject) begin
        cmd_fail_q <= 1'b1;
      end else if (rd_fail_tgt) begin
        cmd_fail_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // next transmit word, ready long before the next frame starts
  scp_out_s tx_d;

  always_comb begin
    tx_d = scp_out_s'(tx_q);
    if (reject) begin
      // repeat the old word; only the length flag is refreshed
      tx_d.frame_error_flag = !frame_len_ok_q;
    end else if (accept) begin
      tx_d.frame_error_flag = 1'b0;
      tx_d.mode_report = do_mode ? cmd.mode_select_field : mode_q;
      tx_d.config_target_field = cmd.config_target_field;
      tx_d.wake_state = wake_level;
      tx_d.data = rd_val[cmd.config_target_field];
      if (do_write) begin
        tx_d.data = cmd.data;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_q <= TX_RST;
    end else if (clk_en && frame_end) begin
      tx_q <= 16'(tx_d);
    end
  end

  // ==========================================================
  // watchdog trigger bit handed on to the supervisor
  logic wd_pulse_q;
  logic wd_level_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wd_pulse_q <= 1'b0;
      wd_level_q <= 1'b0;
    end else if (clk_en) begin
      wd_pulse_q <= accept;
      if (accept) begin
        wd_level_q <= cmd.watchdog_trigger_bit;
      end
    end
  end

  // ==========================================================
  // outputs
  assign op_mode = mode_q;
  assign cfg_regs = cfg_q;
  assign cmd_fail = cmd_fail_q;
  assign cmd_fail_irq = cmd_fail_q & cfg_q[TGT_DEV_IRQ][FAIL_EN_BIT];
  assign wd_trigger_pulse = wd_pulse_q;
  assign wd_trigger_level = wd_level_q;

endmodule // scp_command_port

`default_nettype wire

/* File: scp_monitor.sv */
// checker for the serial command port, bound to its top ports
// assumes: ref_clk domain only; clk_en held high by the bench
`timescale 1ns/1ps
`default_nettype none
module scp_monitor
  import scp_pkg::*;
(
  // system
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // link
  input wire logic spi_clk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  // device
  input wire logic wake_input_pin,
  input wire logic sw_dev_mode,
  input wire logic force_restart,
  input wire logic [2:0] op_mode,
  input wire logic [7:0] cfg_regs [8],
  input wire logic cmd_fail,
  input wire logic cmd_fail_irq,
  input wire logic wd_trigger_pulse,
  input wire logic wd_trigger_level
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================
  // frame position counters, saturating so long idle spans stay legal
  logic [3:0] hi_q, lo_q;
  always_ff @(posedge ref_clk) begin
    if (rst || !chip_select_n) hi_q <= 4'h0;
    else if (hi_q != 4'hf) hi_q <= hi_q + 4'h1;
  end
  always_ff @(posedge ref_clk) begin
    if (rst || chip_select_n) lo_q <= 4'h0;
    else if (lo_q != 4'hf) lo_q <= lo_q + 4'h1;
  end
  // ==========================================
  // assertions
  chk_oe_tracks_cs: assert property (serial_out_oe == !chip_select_n)
    else $error("output enable does not follow chip select");
  chk_out_released: assert property (!serial_out_oe |-> !serial_out)
    else $error("serial output active while released");
  chk_pulse_single: assert property (wd_trigger_pulse |=> !wd_trigger_pulse)
    else $error("frame pulse longer than one cycle");
  chk_pulse_after_rise: assert property (wd_trigger_pulse |-> hi_q >= 2 && hi_q <= 6)
    else $error("word adopted away from chip select rise");
  chk_quiet_in_frame: assert property (lo_q >= 5 |-> !wd_trigger_pulse)
    else $error("word adopted while chip select low");
  chk_irq_gating: assert property (cmd_fail_irq == (cmd_fail && cfg_regs[1][FAIL_EN_BIT]))
    else $error("failure interrupt not gated by its enable");
  chk_restart_forced: assert property (clk_en && force_restart |-> ##[1:2] op_mode == SCP_RESTART)
    else $error("forced restart not entered");
  chk_mode_cause: assert property (op_mode != $past(op_mode) |->
    (wd_trigger_pulse || $past(wd_trigger_pulse) || $past(force_restart)) or (##1 wd_trigger_pulse))
    else $error("mode changed without frame or restart");
  chk_fail_clear: assert property ($fell(cmd_fail) |->
    (wd_trigger_pulse || $past(wd_trigger_pulse)) or (##1 wd_trigger_pulse))
    else $error("failure status cleared without a frame");
  chk_mode_not_ro: assert property (op_mode != SCP_READONLY)
    else $error("reserved mode code reported");
  cover property (wd_trigger_pulse);
  cover property ($rose(cmd_fail));
  cover property (force_restart ##1 op_mode == SCP_RESTART);
endmodule // scp_monitor
`default_nettype wire

/* File: scp_host_model.sv */
// host model: spi master sending one frame per call
// assumes: caller invokes xfer hierarchically; clock stands low between frames
`timescale 1ns/1ps
`default_nettype none
module scp_host_model (
  // link pins
  output logic spi_clk,
  output logic chip_select_n,
  output logic serial_in,
  input wire logic serial_out
);
  logic [15:0] rx_word;
  event done;
  initial begin
    spi_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
  end
  // n clock periods, msb first, data changed after each falling edge
  task automatic xfer(input logic [15:0] w, input int n);
    rx_word = 16'h0000;
    #7 chip_select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      // data moves mid low phase, clear of the sampling falling edge
      #40 serial_in = w[15 - (i % 16)];
      #40 rx_word = {rx_word[14:0], serial_out};
      spi_clk = 1'b1;
      #80 spi_clk = 1'b0;
    end
    #80 chip_select_n = 1'b1;
    // released line shows the inverse so a stale value is never mistaken for data
    serial_in = ~serial_in;
    -> done;
  endtask
endmodule // scp_host_model
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the serial command port
// assumes: host model drives the link; expectations come from a bench-side model
`timescale 1ns/1ps
`default_nettype none
module tb;
  import scp_pkg::*;
  logic ref_clk, rst, clk_en, wake_input_pin, sw_dev_mode, force_restart;
  wire spi_clk, chip_select_n, serial_in, serial_out, serial_out_oe;
  wire cmd_fail, cmd_fail_irq, wd_trigger_pulse, wd_trigger_level;
  scp_mode_e op_mode, md;
  logic [7:0] cfg_regs [8];
  logic [7:0] cf [8];
  logic fl, wdb, wdl;
  logic [15:0] nxt, lf;
  logic [32:0] q [$];
  logic [32:0] e;
  int n_fail, comparisons;
  scp_command_port uut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .spi_clk(spi_clk),
    .chip_select_n(chip_select_n), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .wake_input_pin(wake_input_pin), .sw_dev_mode(sw_dev_mode),
    .force_restart(force_restart), .op_mode(op_mode), .cfg_regs(cfg_regs), .cmd_fail(cmd_fail),
    .cmd_fail_irq(cmd_fail_irq), .wd_trigger_pulse(wd_trigger_pulse),
    .wd_trigger_level(wd_trigger_level));
  scp_host_model host (.spi_clk(spi_clk), .chip_select_n(chip_select_n),
    .serial_in(serial_in), .serial_out(serial_out));
  // ==========================================
  // shared tasks
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string s, input logic [15:0] x, input logic [15:0] g);
    comparisons++;
    if (g !== x) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // d masks the random data; the model is updated before the frame is sent
  task automatic frame(input logic [2:0] m, t, input logic [7:0] d, input int n);
    logic ok;
    logic [7:0] dd, rb;
    logic [15:0] b;
    lf = lfsr(lf);
    dd = d & lf[7:0];
    rb = (t == 3'h1) ? {3'h0, fl, 4'h0} : (t < 3'h4) ? 8'h00 : cf[t];
    ok = n == 16 && m != 3'h0 && !(m == 3'h1 && md != SCP_FLASH)
      && !(m == 3'h2 && md == SCP_STOP) && !(m == 3'h6 && !sw_dev_mode);
    b = (m == 3'h7) ? {nxt[15:8], rb} : nxt;
    b = (n > 16) ? b << (n - 16) : b >> (16 - n);
    wdb = ~wdb;
    if (ok) begin
      if (m != 3'h7) begin
        md = scp_mode_e'(m);
        if (t != 3'h3) cf[t] = dd;
      end
      if (t == 3'h1) fl = 1'b0;
      nxt = {1'b0, md, t, wake_input_pin, (m == 3'h7 || t == 3'h3) ? rb : dd};
      wdl = wdb;
    end else begin
      fl = 1'b1;
      nxt[15] = n != 16;
    end
    q.push_back({t, md, cf[t], fl, fl & cf[1][FAIL_EN_BIT], wdl, b});
    @(negedge ref_clk);
    host.xfer({wdb, m, t, 1'b0, dd}, n);
    repeat (10) @(negedge ref_clk);
  endtask
  // ==========================================
  // clock, watcher, watchdog
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial forever begin
    @(host.done);
    e = q.pop_front();
    chk("rx", e[15:0], host.rx_word);
    repeat (8) @(negedge ref_clk);
    chk("state", {2'b00, e[29:16]}, {2'b00, op_mode, cfg_regs[e[32:30]], cmd_fail,
      cmd_fail_irq, wd_trigger_level});
  end
  initial begin
    repeat (10000) @(posedge ref_clk);
    n_fail++;
    $display("FAIL watchdog expected done seen hang");
    finish_test();
  end
  // ==========================================
  // main sequence
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    sw_dev_mode = 1'b0;
    force_restart = 1'b0;
    lf = 16'h0023;
    wake_input_pin = lf[0];
    md = SCP_INIT;
    for (int i = 0; i < 8; i++) cf[i] = (i < 3) ? IRQ_CFG_RST : CFG_RST;
    fl = 1'b0;
    wdb = 1'b0;
    wdl = 1'b0;
    nxt = TX_RST;
    n_fail = 0;
    comparisons = 0;
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    for (int i = 0; i < 8; i++) chk("cfg", {8'h00, cf[i]}, {8'h00, cfg_regs[i]});
    chk("init", 16'h0000, {11'h000, op_mode, cmd_fail, wd_trigger_level});
    frame(3'h3, 3'h4, 8'hff, 16);
    frame(3'h7, 3'h4, 8'hff, 16);
    frame(3'h0, 3'h5, 8'hff, 16);
    frame(3'h3, 3'h5, 8'hff, 15);
    frame(3'h3, 3'h5, 8'hff, 17);
    frame(3'h1, 3'h6, 8'hff, 16);
    @(negedge ref_clk) wake_input_pin = ~wake_input_pin;
    frame(3'h5, 3'h6, 8'hff, 16);
    frame(3'h2, 3'h7, 8'hff, 16);
    frame(3'h4, 3'h0, 8'hff, 16);
    frame(3'h2, 3'h2, 8'hff, 16);
    frame(3'h1, 3'h3, 8'hff, 16);
    frame(3'h6, 3'h1, 8'hff, 16);
    @(negedge ref_clk) sw_dev_mode = 1'b1;
    frame(3'h6, 3'h1, 8'hef, 16);
    frame(3'h0, 3'h5, 8'hff, 16);
    @(negedge ref_clk) force_restart = 1'b1;
    @(negedge ref_clk) force_restart = 1'b0;
    md = SCP_RESTART;
    repeat (3) @(negedge ref_clk);
    chk("restart", {13'h0000, md}, {13'h0000, op_mode});
    frame(3'h7, 3'h5, 8'hff, 16);
    finish_test();
  end
endmodule // tb
bind scp_command_port scp_monitor u_mon (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
  .spi_clk(spi_clk), .chip_select_n(chip_select_n), .serial_in(serial_in),
  .serial_out(serial_out), .serial_out_oe(serial_out_oe), .wake_input_pin(wake_input_pin),
  .sw_dev_mode(sw_dev_mode), .force_restart(force_restart), .op_mode(op_mode),
  .cfg_regs(cfg_regs), .cmd_fail(cmd_fail), .cmd_fail_irq(cmd_fail_irq),
  .wd_trigger_pulse(wd_trigger_pulse), .wd_trigger_level(wd_trigger_level));
`default_nettype wire
